// >>> src/smsq_regs.vh
`ifndef SMSQ_REGS_VH
`define SMSQ_REGS_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define SMSQ_ADR_STBY_CTRL  8'h00
`define SMSQ_ADR_INT_CTRL   8'h01
`define SMSQ_ADR_WD_CTRL    8'h02
`define SMSQ_ADR_WD_COUNT   8'h03
`define SMSQ_ADR_WD_RSTCTL  8'h04
`define SMSQ_ADR_STAT       8'h05
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SMSQ_RST_STBY_CTRL  8'h1f
`define SMSQ_RST_INT_CTRL   8'h00
`define SMSQ_RST_WD_CTRL    8'h00
`define SMSQ_RST_WD_COUNT   8'h00
`define SMSQ_RST_WD_RSTCTL  8'h1f
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SMSQ_STBY_SEL_BIT   7
`define SMSQ_FLOAT_BIT      6
`define SMSQ_STBY_RSVD_BIT  5
`define SMSQ_STBY_ONES      5'h1f
`define SMSQ_EDGE_SEL_BIT   0
`define SMSQ_WD_FLAG_BIT    7
`define SMSQ_WD_MODE_BIT    6
`define SMSQ_WD_RUN_BIT     5
`define SMSQ_WD_CLK_HI      2
`define SMSQ_WD_CLK_LO      0
// ----------------------------------------------------------------
// Timing: prescaler width; divide by 2^(cks+1)
// ----------------------------------------------------------------
`define SMSQ_PRE_W       8
`define SMSQ_PRE_ONES    8'hff
`define SMSQ_WD_COUNT_MAX   8'hff
`endif

// >>> src/smsq_top.v
// Overview of operation
// - Writing standby select bit then a sleep request enters standby.
// - Standby stops chip clock, halts CPU and all peripherals.
// - CPU registers and RAM keep contents: their clocks simply stop.
// - Ports hold or float in standby per the port float bit.
// - Entry keeps interrupt, break, bus, pin, port, pattern and standby registers.
// - Entry reinitialises DMA, timer pulse unit and A/D registers.
// - Entry clears watchdog bits 7..5 and resets reset control to 1f; keeps select and count.
// - Entry reinitialises all serial interface registers.
// - Only NMI edge, power-on or manual reset end standby.
// - NMI wake restarts oscillator and clocks only the watchdog.
// - Watchdog overflow restores full clock, exits, starts NMI processing.
// - Init pin low with NMI high in standby gives power-on reset.
// - Init pin low with NMI low in standby gives manual reset.
// - Standby forces falling NMI edge; falling NMI wakes before manual reset.
// - Edge select 0 is falling, 1 is rising.
// - Standby select and port float cannot be set while watchdog runs.
// - Port float 1 floats ports in standby, 0 holds them.
// - Standby select 0 makes sleep enter light sleep; reset value 0.
`timescale 1ns/10ps
`default_nettype none
`include "smsq_regs.vh"

module smsq_top (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       sleep_exec_i,
  input  wire       light_wake_i,
  input  wire       nmi_pin_i,
  input  wire       init_pin_n_i,
  output wire       cpu_clk_en_o,
  output wire       periph_clk_en_o,
  output wire       wdt_clk_en_o,
  output wire       osc_en_o,
  output wire       standby_o,
  output wire       light_sleep_o,
  output wire       port_float_o,
  output reg        periph_reinit_o,
  output reg        nmi_exc_o,
  output reg        por_o,
  output reg        manual_rst_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] ST_RUN   = 4'h1;
  localparam [3:0] ST_SLEEP = 4'h2;
  localparam [3:0] ST_STBY  = 4'h4;
  localparam [3:0] ST_WAKE  = 4'h8;

  reg  [3:0] state_q;
  reg  [3:0] state_d;
  reg  [7:0] stby_ctrl_q;
  reg  [7:0] int_ctrl_q;
  reg  [7:0] wd_ctrl_q;
  reg  [7:0] wd_count_q;
  reg  [7:0] wd_rstctl_q;
  reg  [7:0] pre_q;
  reg        nmi_s1_q;
  reg        nmi_s2_q;
  reg        nmi_s3_q;
  reg        init_s1_q;
  reg        init_s2_q;
  reg        init_s3_q;

  wire in_run   = state_q[0];
  wire in_sleep = state_q[1];
  wire in_stby  = state_q[2];
  wire in_wake  = state_q[3];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins come from outside the clock domain; third stage only
  // serves edge detection so the first stage feeds nothing else.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_s1_q  <= 1'b0;
      nmi_s2_q  <= 1'b0;
      nmi_s3_q  <= 1'b0;
      init_s1_q <= 1'b1;
      init_s2_q <= 1'b1;
      init_s3_q <= 1'b1;
    end else begin
      nmi_s1_q  <= nmi_pin_i;
      nmi_s2_q  <= nmi_s1_q;
      nmi_s3_q  <= nmi_s2_q;
      init_s1_q <= init_pin_n_i;
      init_s2_q <= init_s1_q;
      init_s3_q <= init_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  // Standby ignores the stored select and always uses falling edge
  wire edge_rise = (int_ctrl_q[`SMSQ_EDGE_SEL_BIT] == 1'b1) && !in_stby;
  wire nmi_fall  = nmi_s3_q & ~nmi_s2_q;
  wire nmi_rise  = ~nmi_s3_q & nmi_s2_q;
  wire nmi_edge  = edge_rise ? nmi_rise : nmi_fall;
  wire init_fall = init_s3_q & ~init_s2_q;
  wire stby_sel  = stby_ctrl_q[`SMSQ_STBY_SEL_BIT];
  wire wd_run    = wd_ctrl_q[`SMSQ_WD_RUN_BIT];
  wire [2:0] wd_sel = wd_ctrl_q[`SMSQ_WD_CLK_HI:`SMSQ_WD_CLK_LO];
  wire enter_stby = in_run & sleep_exec_i & stby_sel;
  // NMI edge outranks a simultaneous init pin fall in standby
  wire stby_nmi  = in_stby & nmi_fall;
  wire rst_evt   = init_fall & ~stby_nmi;

  // ----------------------------------------------------------------
  // Watchdog prescaler and tick
  // ----------------------------------------------------------------
  // Divide by 2^(cks+1); cks is held across standby, so the wake
  // interval is the one chosen before entry.
  wire [7:0] dmask   = `SMSQ_PRE_ONES >> (3'd7 - wd_sel);
  wire       wdt_go  = in_wake | (wd_run & (in_run | in_sleep));
  wire       tick    = wdt_go && ((pre_q & dmask) == dmask);
  wire       wd_wrap = tick && (wd_count_q == `SMSQ_WD_COUNT_MAX);
  wire [7:0] wd_ctrl_rst = `SMSQ_RST_WD_CTRL;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= 8'h00;
    end else if (wdt_go) begin
      pre_q <= pre_q + 8'h01;
    end else begin
      pre_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_exec_i) begin
          state_d = stby_sel ? ST_STBY : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (light_wake_i) begin
          state_d = ST_RUN;
        end
      end
      ST_STBY: begin
        // Only this NMI fall or the init pin reset below can leave this state
        if (stby_nmi) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wd_wrap) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
    if (rst_evt) begin
      state_d = ST_RUN;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  // Registered so each leaves on a clean flop edge
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      periph_reinit_o <= 1'b0;
      nmi_exc_o       <= 1'b0;
      por_o           <= 1'b0;
      manual_rst_o    <= 1'b0;
    end else begin
      periph_reinit_o <= enter_stby;
      nmi_exc_o       <= (in_wake & wd_wrap & ~rst_evt)
                       | (nmi_edge & ~in_stby & ~in_wake & ~rst_evt);
      por_o           <= rst_evt & nmi_s2_q;
      manual_rst_o    <= rst_evt & ~nmi_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Standby control and interrupt control registers
  // ----------------------------------------------------------------
  wire wr_stc = wr_i & (addr_i == `SMSQ_ADR_STBY_CTRL);
  wire wr_itc = wr_i & (addr_i == `SMSQ_ADR_INT_CTRL);
  wire wr_tcs = wr_i & (addr_i == `SMSQ_ADR_WD_CTRL);
  wire wr_cnt = wr_i & (addr_i == `SMSQ_ADR_WD_COUNT);
  wire wr_rcs = wr_i & (addr_i == `SMSQ_ADR_WD_RSTCTL);
  wire por_evt = rst_evt & nmi_s2_q;

  // Both bits stay frozen while the watchdog runs, so a running
  // watchdog is stopped by standby only if standby was selected before it started.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stby_ctrl_q <= `SMSQ_RST_STBY_CTRL;
      int_ctrl_q  <= `SMSQ_RST_INT_CTRL;
    end else if (por_evt) begin
      stby_ctrl_q <= `SMSQ_RST_STBY_CTRL;
      int_ctrl_q  <= `SMSQ_RST_INT_CTRL;
    end else begin
      // Entry touches neither register
      if (wr_stc && !wd_run) begin
        stby_ctrl_q[`SMSQ_STBY_SEL_BIT] <= wdata_i[`SMSQ_STBY_SEL_BIT];
        stby_ctrl_q[`SMSQ_FLOAT_BIT]    <= wdata_i[`SMSQ_FLOAT_BIT];
      end
      if (wr_itc) begin
        int_ctrl_q <= {7'h00, wdata_i[`SMSQ_EDGE_SEL_BIT]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog registers
  // ----------------------------------------------------------------
  // On entry the upper control bits and reset status go back to
  // reset; clock select and count survive for the wake interval.
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wd_ctrl_q   <= `SMSQ_RST_WD_CTRL;
      wd_count_q  <= `SMSQ_RST_WD_COUNT;
      wd_rstctl_q <= `SMSQ_RST_WD_RSTCTL;
    end else if (por_evt) begin
      wd_ctrl_q   <= `SMSQ_RST_WD_CTRL;
      wd_count_q  <= `SMSQ_RST_WD_COUNT;
      wd_rstctl_q <= `SMSQ_RST_WD_RSTCTL;
    end else if (enter_stby) begin
      wd_ctrl_q[7:5] <= wd_ctrl_rst[7:5];
      wd_rstctl_q    <= `SMSQ_RST_WD_RSTCTL;
    end else begin
      if (wr_tcs) begin
        wd_ctrl_q[6:5] <= wdata_i[6:5];
        wd_ctrl_q[2:0] <= wdata_i[2:0];
        // Software may only clear the flag
        if (!wdata_i[`SMSQ_WD_FLAG_BIT]) begin
          wd_ctrl_q[`SMSQ_WD_FLAG_BIT] <= 1'b0;
        end
      end
      // Overflow set wins over a clearing write in the same cycle
      if (wd_wrap && in_run) begin
        wd_ctrl_q[`SMSQ_WD_FLAG_BIT] <= 1'b1;
      end
      if (wr_rcs) begin
        wd_rstctl_q <= wdata_i;
      end
      if (wr_cnt) begin
        wd_count_q <= wdata_i;
      end else if (tick) begin
        wd_count_q <= wd_count_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and port control
  // ----------------------------------------------------------------
  // CPU and RAM keep state because their clock just stops
  assign cpu_clk_en_o    = in_run;
  assign periph_clk_en_o = in_run | in_sleep;
  assign wdt_clk_en_o    = ~in_stby;
  assign osc_en_o        = ~in_stby;
  assign standby_o       = in_stby | in_wake;
  assign light_sleep_o   = in_sleep;
  // Float while stopped and through the wake period; both count as standby
  assign port_float_o    = standby_o & stby_ctrl_q[`SMSQ_FLOAT_BIT];

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data stands one cycle after the strobe; unmapped reads zero
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SMSQ_ADR_STBY_CTRL: rdata_o <= {stby_ctrl_q[7:6], 1'b0, `SMSQ_STBY_ONES};
        `SMSQ_ADR_INT_CTRL:  rdata_o <= int_ctrl_q;
        `SMSQ_ADR_WD_CTRL:   rdata_o <= {wd_ctrl_q[7:5], 2'b11, wd_ctrl_q[2:0]};
        `SMSQ_ADR_WD_COUNT:  rdata_o <= wd_count_q;
        `SMSQ_ADR_WD_RSTCTL: rdata_o <= wd_rstctl_q;
        `SMSQ_ADR_STAT:   rdata_o <= {2'b00, nmi_s2_q, init_s2_q, state_q};
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // smsq_top
`default_nettype wire

// >>> tb/smsq_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module smsq_top_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sleep_exec_i,
  input wire logic nmi_pin_i,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic wdt_clk_en_o,
  input wire logic osc_en_o,
  input wire logic standby_o,
  input wire logic light_sleep_o,
  input wire logic port_float_o,
  input wire logic periph_reinit_o,
  input wire logic nmi_exc_o,
  input wire logic por_o,
  input wire logic manual_rst_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Pin levels long enough to have crossed the synchroniser
  sequence s_hi; nmi_pin_i [*8]; endsequence
  sequence s_lo; !nmi_pin_i [*8]; endsequence
  sequence s_rise; !nmi_pin_i [*6] ##1 nmi_pin_i [*4]; endsequence
  property p_entry; sleep_exec_i && cpu_clk_en_o |=> standby_o != light_sleep_o; endproperty
  a_entry: assert property (p_entry)
    else $error("sleep gave no low power state");
  property p_halt; standby_o && !osc_en_o |-> !(cpu_clk_en_o || periph_clk_en_o || wdt_clk_en_o);
  endproperty
  a_halt: assert property (p_halt)
    else $error("clock running in standby");
  property p_float; port_float_o |-> standby_o; endproperty
  a_float: assert property (p_float)
    else $error("ports floated outside standby");
  property p_reinit; $fell(cpu_clk_en_o) |-> periph_reinit_o == standby_o; endproperty
  a_reinit: assert property (p_reinit)
    else $error("reinit pulse wrong at entry");
  property p_exit; $fell(standby_o) |-> ##[0:1] (por_o || manual_rst_o || nmi_exc_o); endproperty
  a_exit: assert property (p_exit)
    else $error("standby left without a wake cause");
  property p_wake; standby_o && osc_en_o |-> wdt_clk_en_o && !cpu_clk_en_o && !periph_clk_en_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("settling clocks wrong");
  property p_por; s_hi |=> !manual_rst_o; endproperty
  a_por: assert property (p_por)
    else $error("manual reset with NMI high");
  property p_man; s_lo |=> !por_o; endproperty
  a_man: assert property (p_man)
    else $error("power-on reset with NMI low");
  property p_rise; !osc_en_o throughout s_rise |=> !osc_en_o; endproperty
  a_rise: assert property (p_rise)
    else $error("rising NMI woke standby");
endmodule // smsq_top_assertions
bind smsq_top smsq_top_assertions i_smsq_top_assertions (.*);
`default_nettype wire

// >>> tb/smsq_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Outside system on NMI and init pins
// ----------------------------------------
module smsq_partner (
  input  wire logic clock_i,
  output logic      nmi_o,
  output logic      init_n_o
);
  // Idle: init released, NMI low
  initial begin
    nmi_o = 1'b0;
    init_n_o = 1'b1;
  end
  // Levels only move after an edge and then stand; no glitches
  task automatic set_nmi(input logic v);
    @(posedge clock_i);
    nmi_o <= v;
  endtask
  // Caller fixes NMI first, which picks the reset kind
  task automatic set_init(input logic v);
    @(posedge clock_i);
    init_n_o <= v;
  endtask
endmodule // smsq_partner
`default_nettype wire

// >>> tb/smsq_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "smsq_regs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h seen %h", n, e, g); end end
module smsq_bench;
  logic       clock_i, rst_i, wr_i, rd_i, sleep_exec_i, light_wake_i, nmi_pin_i, init_pin_n_i;
  logic [7:0] addr_i, wdata_i, rdata_o, d, m_stby, m_wdc;
  logic       cpu_clk_en_o, periph_clk_en_o, wdt_clk_en_o, osc_en_o, standby_o;
  logic       light_sleep_o, port_float_o, periph_reinit_o, nmi_exc_o, por_o, manual_rst_o;
  int         error_cnt, checks, n, cks, t, p;
  smsq_top i_smsq_top (.*);
  smsq_partner i_smsq_partner (.clock_i(clock_i), .nmi_o(nmi_pin_i), .init_n_o(init_pin_n_i));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // ----------------------------------------
  // Bus tasks; the model follows standby control and watchdog control writes
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    if (a == `SMSQ_ADR_STBY_CTRL && !m_wdc[5]) m_stby = v & 8'hc0;
    if (a == `SMSQ_ADR_WD_CTRL) m_wdc = v & 8'h67;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic sleep();
    @(posedge clock_i);
    sleep_exec_i <= 1'b1;
    @(posedge clock_i);
    sleep_exec_i <= 1'b0;
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard: whole run needs well under 8k cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_i, wr_i, rd_i, sleep_exec_i, light_wake_i, addr_i, wdata_i} = 21'h100000;
    {m_stby, m_wdc, error_cnt, checks} = 0;
    void'($urandom(66038));
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`SMSQ_ADR_STBY_CTRL);
    `CHK("stby_ctrl reset", 8'h1f, d)
    rd(8'h3c);
    `CHK("unmapped", 8'h00, d)
    wr(`SMSQ_ADR_WD_CTRL, 8'h20);
    wr(`SMSQ_ADR_STBY_CTRL, 8'hc0);
    rd(`SMSQ_ADR_STBY_CTRL);
    `CHK("stby_ctrl locked", m_stby | 8'h1f, d)
    done("refusal");
    // Interval kept above settling time; start count near the top to stay short
    cks = $urandom % 8;
    t = 240 + $urandom % 16;
    p = 2 << cks;
    wr(`SMSQ_ADR_WD_CTRL, 8'h40 | cks[7:0]);
    wr(`SMSQ_ADR_WD_COUNT, t[7:0]);
    wr(`SMSQ_ADR_INT_CTRL, 8'h01);
    wr(`SMSQ_ADR_STBY_CTRL, 8'hc0);
    sleep();
    m_wdc = m_wdc & 8'h07;
    `CHK("standby", 1'b1, standby_o)
    `CHK("float", 1'b1, port_float_o)
    `CHK("reinit", 1'b1, periph_reinit_o)
    repeat (8) tick();
    i_smsq_partner.set_nmi(1'b1);
    repeat (10) tick();
    `CHK("no rise wake", 1'b0, osc_en_o)
    i_smsq_partner.set_nmi(1'b0);
    for (n = 0; osc_en_o !== 1'b1 && n < 10; n++) tick();
    `CHK("wdt only", 1'b1, wdt_clk_en_o && !cpu_clk_en_o)
    for (n = 0; nmi_exc_o !== 1'b1 && n < 5000; n++) tick();
    `CHK("interval", 1'b1, n >= (255 - t) * p && n <= (256 - t) * p + 4)
    `CHK("cpu clock", 1'b1, cpu_clk_en_o)
    rd(`SMSQ_ADR_WD_CTRL);
    `CHK("wd_ctrl", m_wdc | 8'h18, d)
    rd(`SMSQ_ADR_STBY_CTRL);
    `CHK("stby_ctrl held", m_stby | 8'h1f, d)
    rd(`SMSQ_ADR_INT_CTRL);
    `CHK("int_ctrl held", 8'h01, d)
    done("nmi wake");
    // Init pin held low until a reset kind shows, then released
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(`SMSQ_ADR_STBY_CTRL, 8'h80);
      i_smsq_partner.set_nmi(k == 0);
      repeat (8) tick();
      sleep();
      i_smsq_partner.set_init(1'b0);
      for (n = 0; por_o !== 1'b1 && manual_rst_o !== 1'b1 && n < 20; n++) tick();
      `CHK("reset kind", k == 0, por_o)
      `CHK("manual kind", k == 1, manual_rst_o)
      i_smsq_partner.set_init(1'b1);
      tick();
      `CHK("back to run", 1'b0, standby_o)
    end
    rd(`SMSQ_ADR_STBY_CTRL);
    `CHK("stby_ctrl kept", 8'h9f, d)
    done("init pin");
    wr(`SMSQ_ADR_STBY_CTRL, 8'h00);
    sleep();
    `CHK("light", 1'b1, light_sleep_o && periph_clk_en_o && !standby_o)
    light_wake_i <= 1'b1;
    tick();
    light_wake_i <= 1'b0;
    tick();
    `CHK("light end", 1'b0, light_sleep_o)
    done("light sleep");
    wrap_up();
  end
endmodule // smsq_bench
`default_nettype wire
